// [tb_usb_endpoint_mode_responder.sv]
module tb_usb_endpoint_mode_responder import uer_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic tok_stb, dat_start, dat_end, hs_ack, hs_none, rsp_stb, st, tg, ev;
  logic [NUM_EP-1:0] ep_event;
  logic [3:0] m;
  logic [5:0] n, cnt;
  logic [1:0] hs;
  logic [7:0] bad [3] = '{8'h10, 8'h41, 8'h01};
  uer_tok_t tok;
  uer_rx_t rx;
  uer_rsp_t rsp;
  uer_rsp_code_t c;
  uer_pid_t p;
  int num_errors = 0;
  int n_tests = 0;

  uer_responder dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tok_stb(tok_stb), .tok(tok), .dat_start(dat_start),
    .dat_end(dat_end), .rx(rx), .hs_ack(hs_ack), .hs_none(hs_none),
    .rsp_stb(rsp_stb), .rsp(rsp), .ep_event(ep_event));
  uer_host_model host_u (.pclk(pclk), .tok_stb(tok_stb), .tok(tok),
    .dat_start(dat_start), .dat_end(dat_end), .rx(rx), .hs_ack(hs_ack),
    .hs_none(hs_none), .rsp_stb(rsp_stb), .rsp(rsp), .ep_event(ep_event));

  // compare and count
  task automatic chk(input string nm, input logic [31:0] s,
    input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // apb transfer, result in rd and err
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    int t;
    t = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (t >= 20) num_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // expected answer per mode and token
  function automatic uer_rsp_code_t exp_code(logic [3:0] m, uer_pid_t p,
    logic st, logic zk);
    logic [15:0] acc = 16'hcc5e;
    case (p)
      PID_SETUP: return acc[m] ? RSP_ACK : RSP_NONE;
      PID_IN: case (m)
        4'h1, 4'hc, 4'he: return RSP_NAK;
        4'h2, 4'h3: return RSP_STALL;
        4'h6, 4'ha, 4'hb: return RSP_TX0;
        4'h7, 4'hf: return RSP_TXCNT;
        4'hd: return st ? RSP_STALL : RSP_TXCNT;
        default: return RSP_NONE;
      endcase
      default: case (m)
        4'h1, 4'h8, 4'ha: return RSP_NAK;
        4'h3, 4'h6: return RSP_STALL;
        4'hb: return RSP_ACK;
        4'h9: return st ? RSP_STALL : RSP_ACK;
        4'h2, 4'he, 4'hf: return zk ? RSP_ACK : RSP_STALL;
        default: return RSP_NONE;
      endcase
    endcase
  endfunction

  // expected mode after the transaction
  function automatic logic [3:0] nxt(logic [3:0] m, uer_pid_t p,
    uer_rsp_code_t c, logic [1:0] h);
    if (p == PID_SETUP && c == RSP_ACK) return MD_NAK_INOUT;
    if (m inside {4'h9, 4'hb, 4'hf} && p == PID_OUT && c == RSP_ACK)
      return {m[3:1], 1'b0};
    if (m == 4'hd && c == RSP_TXCNT && h == 2'd1)
      return {m[3:1], 1'b0};
    return m;
  endfunction

  task automatic tally_and_finish();
    if (num_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // watchdog
  initial begin
    #400000;
    num_errors++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    void'($urandom(32'h2e9c));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 16; a += 4) begin
      apb(1'b0, 8'(a), '0);
      chk("reset", rd, RD_ZERO);
    end
    foreach (bad[i]) begin
      apb(1'b0, bad[i], '0);
      chk("slverr", 32'(err), 32'h1);
      chk("err data", rd, RD_ZERO);
    end
    apb(1'b1, 8'h00, 32'h2);
    host_u.xfer(1'b0, PID_SETUP, 6'd10, 1'b0, 1'b1, 2'd0);
    chk("setup", 32'(host_u.seen.code), 32'(RSP_ACK));
    apb(1'b1, 8'h00, 32'h2);
    apb(1'b0, 8'h00, '0);
    chk("mode0 lock", 32'(rd[4:0]), 32'h11);
    chk("setup flag", 32'(rd[8]), 32'h0);
    apb(1'b1, 8'h04, 32'h5);
    apb(1'b0, 8'h04, '0);
    chk("cnt0 lock", rd, 32'h4a);
    apb(1'b1, 8'h04, 32'h5);
    apb(1'b0, 8'h04, '0);
    chk("cnt0 open", rd, 32'h5);
    apb(1'b1, 8'h00, 32'h2);
    apb(1'b0, 8'h00, '0);
    chk("mode0 open", rd, 32'h2);
    for (int k = 0; k < 96; k++) begin
      m = k[3:0];
      p = uer_pid_t'(2'(k / 32));
      st = (m == 4'h9 || m == 4'hd) && $urandom_range(1);
      n = $urandom_range(1) ? 6'd2 : 6'($urandom_range(10, 2));
      tg = 1'($urandom_range(1));
      cnt = 6'($urandom_range(8));
      c = exp_code(m, p, st, n == 6'd2 && tg);
      hs = (c inside {RSP_TX0, RSP_TXCNT} && m != 4'h7) ?
        2'($urandom_range(2, 1)) : 2'd0;
      ev = c != RSP_NONE || (p == PID_OUT && m == 4'h5);
      apb(1'b1, 8'h08, {24'h0, st, 3'h0, m});
      apb(1'b1, 8'h0c, {24'h0, tg, 1'b0, cnt});
      host_u.xfer(1'b1, p, n, tg, 1'b1, hs);
      chk("answered", 32'(host_u.got), 32'(c != RSP_NONE));
      if (c != RSP_NONE) chk("code", 32'(host_u.seen.code), 32'(c));
      if (c == RSP_TXCNT) chk("len", 32'(host_u.seen.len), 32'(cnt));
      if (c inside {RSP_TX0, RSP_TXCNT})
        chk("tog", 32'(host_u.seen.data_toggle_bit), 32'(tg));
      chk("event", 32'(host_u.evt), 32'(ev));
      apb(1'b0, 8'h08, '0);
      chk("mode", 32'(rd[3:0]), 32'(nxt(m, p, c, hs)));
      chk("flags", 32'(rd[6:5]), 32'({ev && p == PID_IN,
        ev && p == PID_OUT}));
    end
    for (int j = 0; j < 2; j++) begin
      apb(1'b1, 8'h08, 32'hb);
      host_u.xfer(1'b1, PID_OUT, j ? 6'd4 : 6'd11, 1'b1, j == 0, 2'd0);
      chk("bad pkt", 32'(host_u.got), 32'h0);
      chk("bad evt", 32'(host_u.evt), 32'h1);
    end
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h08, '0);
    chk("rereset", rd, RD_ZERO);
    tally_and_finish();
  end
endmodule

// [uer_host_model.sv]
// usb host side: issues tokens, data and handshakes
module uer_host_model import uer_pkg::*; (
  input wire logic pclk, // clock
  output logic tok_stb, // token strobe
  output uer_tok_t tok, // token
  output logic dat_start, // data start
  output logic dat_end, // data end
  output uer_rx_t rx, // packet summary
  output logic hs_ack, // host acked data
  output logic hs_none, // host gave no handshake
  input wire logic rsp_stb, // answer strobe
  input wire uer_rsp_t rsp, // answer
  input wire logic [NUM_EP-1:0] ep_event // event pulses
);
  timeunit 1ns;
  timeprecision 1ns;
  logic got;
  logic evt;
  uer_rsp_t seen;

  // idle levels
  initial begin
    tok_stb = 1'b0;
    tok = '0;
    dat_start = 1'b0;
    dat_end = 1'b0;
    rx = '0;
    hs_ack = 1'b0;
    hs_none = 1'b0;
  end

  // one transaction; hs 1 acks data, 2 gives no handshake
  task automatic xfer(input logic [EP_W-1:0] ep, input uer_pid_t pid,
    input logic [5:0] n, input logic tg, input logic crc,
    input logic [1:0] hs);
    got = 1'b0;
    evt = 1'b0;
    @(posedge pclk);
    tok_stb <= 1'b1;
    tok <= '{pid: pid, ep: ep};
    @(posedge pclk);
    tok_stb <= 1'b0;
    tok <= uer_tok_t'(~tok); // stale fields do not linger
    if (pid != PID_IN) begin
      dat_start <= 1'b1;
      @(posedge pclk);
      dat_start <= 1'b0;
      dat_end <= 1'b1;
      rx <= '{bytes: n, crc_ok: crc, data_toggle_bit: tg};
      @(posedge pclk);
      dat_end <= 1'b0;
      rx <= uer_rx_t'(~rx);
    end
    repeat (6) begin
      @(posedge pclk);
      evt = evt | ep_event[ep];
      hs_ack <= rsp_stb && hs == 2'd1 && rsp.code inside {RSP_TX0, RSP_TXCNT};
      hs_none <= rsp_stb && hs == 2'd2 && rsp.code inside {RSP_TX0, RSP_TXCNT};
      if (rsp_stb) begin
        got = 1'b1;
        seen = rsp;
      end
    end
  endtask
endmodule

// [uer_mode_decode.sv]
// mode table: answer for one token given the endpoint's mode
module uer_mode_decode import uer_pkg::*; (
  input wire logic [3:0] mode, // endpoint mode field
  input wire logic stall, // endpoint stall bit
  input wire uer_pid_t pid, // token of this transaction
  input wire logic pkt_ok, // data packet passed size and crc checks
  input wire logic zlen_ok, // zero length with toggle one
  output uer_rsp_code_t code, // answer to send
  output logic take, // data packet goes to the buffer
  output logic no_hs, // isochronous: no handshake follows
  output logic [3:0] ack_next // mode after an ack
);
  logic set_acc;
  logic out_take;
  logic out_chk;
  uer_rsp_code_t in_c;
  uer_rsp_code_t out_c;
  uer_rsp_code_t out_eff;

  // per-mode answer to each token kind
  always_comb begin
    set_acc = 1'b0;
    in_c = RSP_NONE;
    out_c = RSP_NONE;
    out_take = 1'b0;
    out_chk = 1'b0;
    no_hs = 1'b0;
    case (mode)
      MD_DISABLE: set_acc = 1'b0;
      MD_NAK_INOUT: begin
        set_acc = 1'b1;
        in_c = RSP_NAK;
        out_c = RSP_NAK;
      end
      MD_STATUS_OUT: begin
        set_acc = 1'b1;
        in_c = RSP_STALL;
        out_chk = 1'b1;
      end
      MD_STALL_INOUT: begin
        set_acc = 1'b1;
        in_c = RSP_STALL;
        out_c = RSP_STALL;
      end
      MD_IGNORE_INOUT: set_acc = 1'b1;
      MD_STATUS_IN: begin
        set_acc = 1'b1;
        in_c = RSP_TX0;
        out_c = RSP_STALL;
      end
      MD_ISO_OUT: out_take = 1'b1;
      MD_ISO_IN: begin
        in_c = RSP_TXCNT;
        no_hs = 1'b1;
      end
      MD_NAK_OUT: out_c = RSP_NAK;
      MD_ACK_OUT: begin
        out_c = stall ? RSP_STALL : RSP_ACK;
        out_take = !stall;
      end
      MD_NAK_OUT_STIN: begin
        set_acc = 1'b1;
        in_c = RSP_TX0;
        out_c = RSP_NAK;
      end
      MD_ACK_OUT_STIN: begin
        set_acc = 1'b1;
        in_c = RSP_TX0;
        out_c = RSP_ACK;
        out_take = 1'b1;
      end
      MD_NAK_IN: in_c = RSP_NAK;
      MD_ACK_IN: in_c = stall ? RSP_STALL : RSP_TXCNT;
      MD_NAK_IN_STOUT: begin
        set_acc = 1'b1;
        in_c = RSP_NAK;
        out_chk = 1'b1;
      end
      MD_ACK_IN_STOUT: begin
        set_acc = 1'b1;
        in_c = RSP_TXCNT;
        out_chk = 1'b1;
      end
      default: set_acc = 1'b0;
    endcase
  end

  // checked out: ack only zero length toggle one
  always_comb begin
    out_eff = out_c;
    if (out_chk) begin
      out_eff = zlen_ok ? RSP_ACK : RSP_STALL;
    end
  end

  // pick by token; invalid packets get no handshake
  always_comb begin
    code = RSP_NONE;
    take = 1'b0;
    case (pid)
      PID_SETUP: begin
        take = set_acc;
        if (set_acc && pkt_ok) begin
          code = RSP_ACK;
        end
      end
      PID_IN: code = in_c;
      PID_OUT: begin
        take = out_take;
        if (pkt_ok) begin
          code = out_eff;
        end
      end
      default: code = RSP_NONE;
    endcase
  end

  // automatic mode moves after an ack
  always_comb begin
    ack_next = mode;
    if (pid == PID_SETUP) begin
      ack_next = MD_NAK_INOUT;
    end else if ((pid == PID_OUT && (mode == MD_ACK_OUT ||
        mode == MD_ACK_OUT_STIN || mode == MD_ACK_IN_STOUT)) ||
        (pid == PID_IN && mode == MD_ACK_IN)) begin
      ack_next = mode & ACK_NAK_MASK;
    end
  end
endmodule

// [uer_pkg.sv]
package uer_pkg;
  // endpoint set and packet limits
  localparam int NUM_EP = 2;
  localparam int EP_W = 1;
  localparam logic [5:0] EP_SIZE = 6'h08;
  localparam logic [5:0] CRC_BYTES = 6'h02;
  localparam logic [EP_W-1:0] LOCK_EP = 1'h0;

  // apb address layout: mode word then count word per endpoint
  localparam int ADDR_W = 8;
  localparam int SEL_BIT = 2;
  localparam int EP_LSB = 3;
  localparam int ALIGN_W = 2;
  localparam logic [ALIGN_W-1:0] ALIGN_OK = 2'h0;
  localparam logic [ADDR_W-EP_LSB-EP_W-1:0] HIGH_OK = 4'h0;

  // mode register bits
  localparam int MODE_W = 4;
  localparam int MB_ACK = 4;
  localparam int MB_OUT = 5;
  localparam int MB_IN = 6;
  localparam int MB_STALL = 7;
  localparam int MB_SETUP = 8;
  // count register bits
  localparam int CNT_W = 6;
  localparam int CB_VALID = 6;
  localparam int CB_TOG = 7;
  localparam logic [31:0] RD_ZERO = 32'h0;
  localparam logic [CNT_W-1:0] CNT_RST = 6'h00;

  // endpoint mode field encodings
  localparam logic [3:0] MD_DISABLE = 4'h0;
  localparam logic [3:0] MD_NAK_INOUT = 4'h1;
  localparam logic [3:0] MD_STATUS_OUT = 4'h2;
  localparam logic [3:0] MD_STALL_INOUT = 4'h3;
  localparam logic [3:0] MD_IGNORE_INOUT = 4'h4;
  localparam logic [3:0] MD_ISO_OUT = 4'h5;
  localparam logic [3:0] MD_STATUS_IN = 4'h6;
  localparam logic [3:0] MD_ISO_IN = 4'h7;
  localparam logic [3:0] MD_NAK_OUT = 4'h8;
  localparam logic [3:0] MD_ACK_OUT = 4'h9;
  localparam logic [3:0] MD_NAK_OUT_STIN = 4'ha;
  localparam logic [3:0] MD_ACK_OUT_STIN = 4'hb;
  localparam logic [3:0] MD_NAK_IN = 4'hc;
  localparam logic [3:0] MD_ACK_IN = 4'hd;
  localparam logic [3:0] MD_NAK_IN_STOUT = 4'he;
  localparam logic [3:0] MD_ACK_IN_STOUT = 4'hf;
  localparam logic [3:0] ACK_NAK_MASK = 4'he;

  typedef enum logic [1:0] {
    PID_SETUP = 2'b00,
    PID_IN = 2'b01,
    PID_OUT = 2'b10
  } uer_pid_t;

  typedef enum logic [2:0] {
    RSP_NONE = 3'b000,
    RSP_ACK = 3'b001,
    RSP_NAK = 3'b010,
    RSP_STALL = 3'b011,
    RSP_TX0 = 3'b100,
    RSP_TXCNT = 3'b101
  } uer_rsp_code_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DATA = 2'b01,
    ST_INACK = 2'b10
  } uer_state_t;

  typedef struct packed {
    uer_pid_t pid;
    logic [EP_W-1:0] ep;
  } uer_tok_t;

  typedef struct packed {
    logic [CNT_W-1:0] bytes;
    logic crc_ok;
    logic data_toggle_bit;
  } uer_rx_t;

  typedef struct packed {
    uer_rsp_code_t code;
    logic [CNT_W-1:0] len;
    logic data_toggle_bit;
  } uer_rsp_t;
endpackage

// [uer_responder.sv]
// Behaviour
// - mode 0000 answers no token at all
// - mode 0001 accepts setup, naks in and out
// - control modes 0010 0011 0100 0110 answer
// - mode 1001 acks or stalls out, then 1000
// - mode 1000 naks out, ignores rest
// - modes 1011 and 1010 status in pair
// - mode 1101 sends data, then 1100 naks in
// - mode 1111 sends data, then 1110 after status
// - checked out acks zero length toggle one
// - counted in sends byte count bytes
// - zero length in sends empty packet
// - ignore sends no handshake to in or out; setup is still acked
// - reset disables; stays until firmware writes
// - accepted setup moves mode to 0001
// - accepted valid setup is acked
// - invalid transactions are silently ignored
// - event on completion or bad crc data
// - data valid if size fits and crc ok
// - out endpoints ignore in, and reverse
// - in/out flags at end, setup at data
// - endpoint 0 ack locks mode and count
// - setup flag never locked; read unlocks
module uer_responder import uer_pkg::*; (
  input wire logic pclk, // bus and engine clock
  input wire logic presetn, // asynchronous reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic tok_stb, // token received
  input wire uer_tok_t tok, // token kind and endpoint
  input wire logic dat_start, // data packet begins
  input wire logic dat_end, // data packet ends
  input wire uer_rx_t rx, // data packet summary at dat_end
  input wire logic hs_ack, // host acked our data
  input wire logic hs_none, // host gave no handshake
  output logic rsp_stb, // send answer now
  output uer_rsp_t rsp, // answer for the serial_interface_engine
  output logic [NUM_EP-1:0] ep_event // endpoint event pulse
);
  uer_state_t state_reg;
  uer_state_t state_next;
  uer_pid_t cur_pid_reg;
  logic [EP_W-1:0] cur_ep_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic rsp_stb_reg;
  uer_rsp_t rsp_reg;
  logic [NUM_EP-1:0] ep_event_reg;

  wire [3:0] mode_w [NUM_EP];
  wire [CNT_W-1:0] cnt_w [NUM_EP];
  wire [NUM_EP-1:0] stall_w;
  wire [NUM_EP-1:0] ack_w;
  wire [NUM_EP-1:0] in_w;
  wire [NUM_EP-1:0] out_w;
  wire [NUM_EP-1:0] setup_w;
  wire [NUM_EP-1:0] valid_w;
  wire [NUM_EP-1:0] tog_w;

  logic idle;
  uer_pid_t ctx_pid;
  logic [EP_W-1:0] ctx_ep;
  logic pkt_ok;
  logic zlen_ok;
  uer_rsp_code_t dec_code;
  logic dec_take;
  logic dec_no_hs;
  logic [3:0] dec_ack_next;
  logic done;
  logic done_ack;
  logic rsp_go;
  logic setup_hit;
  logic act;

  logic apb_setup;
  logic apb_fire;
  logic apb_map;
  logic [EP_W-1:0] apb_ep;
  logic apb_cnt;
  logic [31:0] rd_word;

  // transaction context: the token while idle, then the stored one
  assign idle = state_reg == ST_IDLE;
  assign ctx_pid = idle ? tok.pid : cur_pid_reg;
  assign ctx_ep = idle ? tok.ep : cur_ep_reg;

  // size including crc within limit and crc good
  assign pkt_ok = rx.crc_ok && (rx.bytes <= EP_SIZE + CRC_BYTES);
  assign zlen_ok = rx.bytes == CRC_BYTES && rx.data_toggle_bit;

  uer_mode_decode u_dec (
    .mode(mode_w[ctx_ep]),
    .stall(stall_w[ctx_ep]),
    .pid(ctx_pid),
    .pkt_ok(pkt_ok),
    .zlen_ok(zlen_ok),
    .code(dec_code),
    .take(dec_take),
    .no_hs(dec_no_hs),
    .ack_next(dec_ack_next)
  );

  // transaction sequencing
  always_comb begin
    state_next = state_reg;
    done = 1'b0;
    done_ack = 1'b0;
    rsp_go = 1'b0;
    setup_hit = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (tok_stb && tok.pid == PID_IN) begin
          rsp_go = dec_code != RSP_NONE;
          if ((dec_code == RSP_TX0 || dec_code == RSP_TXCNT) &&
              !dec_no_hs) begin
            state_next = ST_INACK;
          end else begin
            done = 1'b1;
          end
        end else if (tok_stb) begin
          state_next = ST_DATA;
        end
      end
      ST_DATA: begin
        setup_hit = dat_start && cur_pid_reg == PID_SETUP && dec_take;
        if (dat_end) begin
          done = 1'b1;
          rsp_go = dec_code != RSP_NONE;
          done_ack = dec_code == RSP_ACK;
          state_next = ST_IDLE;
        end
      end
      ST_INACK: begin
        if (hs_ack || hs_none) begin
          done = 1'b1;
          done_ack = hs_ack;
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // event on a completed or corrupted transaction
  assign act = done && (dec_code != RSP_NONE || dec_take);

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // token capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_pid_reg <= PID_SETUP;
      cur_ep_reg <= '0;
    end else if (idle && tok_stb) begin
      cur_pid_reg <= tok.pid;
      cur_ep_reg <= tok.ep;
    end
  end

  // answer to the serial_interface_engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_stb_reg <= 1'b0;
      rsp_reg <= '{RSP_NONE, CNT_RST, 1'b0};
    end else begin
      rsp_stb_reg <= rsp_go;
      if (rsp_go) begin
        rsp_reg.code <= dec_code;
        // counted data uses byte count; empty otherwise
        rsp_reg.len <= (dec_code == RSP_TXCNT) ? cnt_w[ctx_ep] : CNT_RST;
        rsp_reg.data_toggle_bit <= tog_w[ctx_ep];
      end
    end
  end

  // endpoint event pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ep_event_reg <= '0;
    end else begin
      ep_event_reg <= act ? (NUM_EP'(1) << ctx_ep) : '0;
    end
  end

  // apb decode: no wait state, data prepared in setup phase
  assign apb_setup = psel && !penable;
  assign apb_fire = psel && penable && pready_reg;
  assign apb_ep = paddr[EP_LSB +: EP_W];
  assign apb_cnt = paddr[SEL_BIT];
  assign apb_map = paddr[ALIGN_W-1:0] == ALIGN_OK &&
                   paddr[ADDR_W-1:EP_LSB+EP_W] == HIGH_OK;

  // read word of the addressed register
  always_comb begin
    rd_word = RD_ZERO;
    if (apb_cnt) begin
      rd_word[CNT_W-1:0] = cnt_w[apb_ep];
      rd_word[CB_VALID] = valid_w[apb_ep];
      rd_word[CB_TOG] = tog_w[apb_ep];
    end else begin
      rd_word[MODE_W-1:0] = mode_w[apb_ep];
      rd_word[MB_ACK] = ack_w[apb_ep];
      rd_word[MB_OUT] = out_w[apb_ep];
      rd_word[MB_IN] = in_w[apb_ep];
      rd_word[MB_STALL] = stall_w[apb_ep];
      rd_word[MB_SETUP] = setup_w[apb_ep];
    end
  end

  // apb answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= RD_ZERO;
    end else begin
      pready_reg <= apb_setup;
      if (apb_setup) begin
        pslverr_reg <= !apb_map;
        prdata_reg <= (apb_map && !pwrite) ? rd_word : RD_ZERO;
      end
    end
  end

  // per endpoint register file
  for (genvar i = 0; i < NUM_EP; i++) begin : g_ep
    logic [3:0] mode_reg;
    logic stall_reg;
    logic ack_reg;
    logic in_reg;
    logic out_reg;
    logic setup_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic valid_reg;
    logic tog_reg;
    logic lock_mode_reg;
    logic lock_cnt_reg;
    logic hit;
    logic lockable;
    logic wr_mode;
    logic wr_cnt;
    logic rd_mode;
    logic rd_cnt;

    assign hit = ctx_ep == EP_W'(i);
    assign lockable = EP_W'(i) == LOCK_EP;
    assign wr_mode = apb_fire && apb_map && pwrite && apb_ep == EP_W'(i)
                     && !apb_cnt;
    assign wr_cnt = apb_fire && apb_map && pwrite && apb_ep == EP_W'(i)
                    && apb_cnt;
    assign rd_mode = apb_fire && apb_map && !pwrite && apb_ep == EP_W'(i)
                     && !apb_cnt;
    assign rd_cnt = apb_fire && apb_map && !pwrite && apb_ep == EP_W'(i)
                    && apb_cnt;

    // mode field: engine moves win over firmware writes
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mode_reg <= MD_DISABLE;
      end else if (hit && done_ack) begin
        mode_reg <= dec_ack_next;
      end else if (wr_mode && !lock_mode_reg) begin
        mode_reg <= pwdata[MODE_W-1:0];
      end
    end

    // stall bit, firmware only
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        stall_reg <= 1'b0;
      end else if (wr_mode && !lock_mode_reg) begin
        stall_reg <= pwdata[MB_STALL];
      end
    end

    // ack and token flags: hardware set wins over write
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ack_reg <= 1'b0;
        in_reg <= 1'b0;
        out_reg <= 1'b0;
      end else begin
        if (hit && done_ack) begin
          ack_reg <= 1'b1;
        end else if (wr_mode && !lock_mode_reg) begin
          ack_reg <= pwdata[MB_ACK];
        end
        // in and out flags at transaction end
        if (hit && act && ctx_pid == PID_IN) begin
          in_reg <= 1'b1;
        end else if (wr_mode && !lock_mode_reg) begin
          in_reg <= pwdata[MB_IN];
        end
        if (hit && act && ctx_pid == PID_OUT) begin
          out_reg <= 1'b1;
        end else if (wr_mode && !lock_mode_reg) begin
          out_reg <= pwdata[MB_OUT];
        end
      end
    end

    // setup flag writable regardless of lock
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        setup_reg <= 1'b0;
      end else if (hit && setup_hit) begin
        setup_reg <= 1'b1;
      end else if (wr_mode) begin
        setup_reg <= pwdata[MB_SETUP];
      end
    end

    // byte count, valid and toggle from received data
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_reg <= CNT_RST;
        valid_reg <= 1'b0;
        tog_reg <= 1'b0;
      end else if (hit && done && dec_take) begin
        cnt_reg <= rx.bytes;
        valid_reg <= pkt_ok;
        tog_reg <= rx.data_toggle_bit;
      end else if (wr_cnt && !lock_cnt_reg) begin
        cnt_reg <= pwdata[CNT_W-1:0];
        valid_reg <= pwdata[CB_VALID];
        tog_reg <= pwdata[CB_TOG];
      end
    end

    // endpoint 0 ack locks; read of each register unlocks it
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        lock_mode_reg <= 1'b0;
        lock_cnt_reg <= 1'b0;
      end else begin
        lock_mode_reg <= lockable &&
                         ((hit && done_ack) || (lock_mode_reg && !rd_mode));
        lock_cnt_reg <= lockable &&
                        ((hit && done_ack) || (lock_cnt_reg && !rd_cnt));
      end
    end

    assign mode_w[i] = mode_reg;
    assign cnt_w[i] = cnt_reg;
    assign stall_w[i] = stall_reg;
    assign ack_w[i] = ack_reg;
    assign in_w[i] = in_reg;
    assign out_w[i] = out_reg;
    assign setup_w[i] = setup_reg;
    assign valid_w[i] = valid_reg;
    assign tog_w[i] = tog_reg;
  end

  // outputs straight from flops
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign rsp_stb = rsp_stb_reg;
  assign rsp = rsp_reg;
  assign ep_event = ep_event_reg;
endmodule

// [uer_responder_assertions.sv]
// checker on the responder ports
module uer_responder_assertions import uer_pkg::*; (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pready, // apb ready
  input wire logic tok_stb, // token strobe
  input wire logic dat_end, // data packet end
  input wire uer_rx_t rx, // packet summary
  input wire logic rsp_stb, // answer strobe
  input wire uer_rsp_t rsp, // answer
  input wire logic [NUM_EP-1:0] ep_event // event pulses
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // apb answers in the first access cycle, without wait, and only once
  property p_rdy; psel && !penable |=> pready ##1 !pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready timing wrong");
  // empty data packet carries no length
  property p_tx0; rsp_stb && rsp.code == RSP_TX0 |-> rsp.len == 6'h00;
  endproperty
  a_tx0: assert property (p_tx0) else $error("tx0 len not zero");
  // answers follow a token or a data packet
  property p_cause; rsp_stb |-> $past(tok_stb) || $past(dat_end); endproperty
  a_cause: assert property (p_cause) else $error("answer uncaused");
  // an ignore is never strobed out
  property p_nonone; rsp_stb |-> rsp.code != RSP_NONE; endproperty
  a_nonone: assert property (p_nonone) else $error("none strobed");
  // oversized packet gets no answer
  property p_big; dat_end && rx.bytes > EP_SIZE + CRC_BYTES |=> !rsp_stb;
  endproperty
  a_big: assert property (p_big) else $error("oversize answered");
  // bad crc gets no answer
  property p_crc; dat_end && !rx.crc_ok |=> !rsp_stb; endproperty
  a_crc: assert property (p_crc) else $error("bad crc answered");
  // answer holds between strobes
  property p_hold; !rsp_stb |-> $stable(rsp); endproperty
  a_hold: assert property (p_hold) else $error("rsp changed");
  // handshakes raise an event at once
  property p_evt;
    rsp_stb && rsp.code inside {RSP_ACK, RSP_NAK, RSP_STALL}
      |-> ep_event != '0;
  endproperty
  a_evt: assert property (p_evt) else $error("no event");
  // events are single pulses
  property p_evt1; ep_event != '0 |=> ep_event == '0; endproperty
  a_evt1: assert property (p_evt1) else $error("event too long");

  // main scenarios
  c_txcnt: cover property (rsp_stb && rsp.code == RSP_TXCNT);
  c_ack: cover property (dat_end ##1 rsp_stb && rsp.code == RSP_ACK);
  c_badcrc: cover property (dat_end && !rx.crc_ok);
endmodule

bind uer_responder uer_responder_assertions chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .tok_stb(tok_stb), .dat_end(dat_end), .rx(rx),
  .rsp_stb(rsp_stb), .rsp(rsp), .ep_event(ep_event)
);
